// *** design/rts_counter.sv ***
/*
 Reusable down-counter timer: load a count, tick per enable, done pulse.
 Assumes the owner holds load for one cycle and gives a steady tick enable.
*/
module rts_counter #(
    parameter int unsigned WIDTH = 22
) (
    // Clock and control
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // Command
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    input wire logic tick,
    // Status
    output logic running,
    output logic done
);
    logic [WIDTH-1:0] count;
    wire last_tick = running && tick && (count == WIDTH'(1));

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            count <= '0;
            running <= 1'b0;
            done <= 1'b0;
        end
        else if (ce)
        begin
            done <= last_tick;
            if (load)
            begin
                count <= load_value;
                running <= (load_value != '0);
            end
            else if (running && tick)
            begin
                count <= count - WIDTH'(1);
                running <= !last_tick;
            end
        end
    end
endmodule // rts_counter

// *** design/rts_pkg.sv ***
/*
 Package for the reset time-out sequencer: register map, field positions,
 reset values, timing constants, state encoding and carrier structs.
 Assumes a single 40 MHz clock and a plain strobe register port.
*/
package rts_pkg;

    localparam int unsigned CLK_HZ = 40_000_000;

    // Timing figures in their own units
    localparam int unsigned POWERUP_TIMER_MS = 72;
    localparam int unsigned OST_TOSC = 1024;
    localparam int unsigned WDT_MS = 18;
    localparam int unsigned WDT_MIN_MS = 7;
    localparam int unsigned WDT_MAX_MS = 33;

    // Derived cycle counts at the system clock
    localparam int unsigned POWERUP_TIMER_CYCLES = POWERUP_TIMER_MS * (CLK_HZ / 1000);
    localparam int unsigned WDT_CYCLES = WDT_MS * (CLK_HZ / 1000);

    // Register map (word offsets chosen here)
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_EVENTS = 4'h1;
    localparam logic [3:0] ADDR_MASK = 4'h2;
    localparam logic [3:0] ADDR_CTRL = 4'h3;

    // power_reset_status fields
    localparam int unsigned BIT_BROWNOUT = 0;
    localparam int unsigned BIT_POWERON = 1;
    localparam int unsigned BIT_IN_RESET = 7;

    // Event bits
    localparam int unsigned EV_RELEASE = 0;
    localparam int unsigned EV_WDT = 1;
    localparam int unsigned EV_BROWNOUT = 2;

    // Control fields
    localparam int unsigned CTL_WDT_EN = 0;
    localparam int unsigned CTL_WDT_CLR = 1;

    localparam logic [7:0] RST_EVENTS = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_POWERON_ON_POR = 8'h00;

    // Oscillator configuration
    typedef enum logic [1:0] {
        OSC_CRYSTAL_LOWPOWER = 2'b00,
        OSC_CRYSTAL_STANDARD = 2'b01,
        OSC_CRYSTAL_FAST = 2'b10,
        OSC_RESISTOR_CAPACITOR = 2'b11
    } rts_osc_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_POWERUP_TIMER = 2'b01,
        ST_OST = 2'b10,
        ST_RUN = 2'b11
    } rts_state_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rts_bus_req_t;

    typedef struct packed {
        rts_osc_mode_t osc_mode;
        logic powerup_timer_disable;
        logic brownout_reset_enable;
    } rts_cfg_t;

endpackage

// *** design/rts_reset_timeout.sv ***
/*
 Reset time-out sequencer with reset-cause status flags, a watchdog,
 sticky events with mask and a level interrupt.
 Assumes power-on, brown-out and wake-up arrive as one-cycle pulses
 synchronous to clock, and osc_edge pulses once per oscillator period.
*/
// Design decisions made here: the register offsets and the address-and-strobe port.
module rts_reset_timeout #(
    parameter int unsigned POWERUP_TIMER_COUNT = rts_pkg::POWERUP_TIMER_CYCLES,
    parameter int unsigned WDT_COUNT = rts_pkg::WDT_CYCLES
) (
    // Clock, reset, enable
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // Reset sources and configuration
    input wire logic poweron_event,
    input wire logic brownout_event,
    input wire logic wakeup_event,
    input wire logic osc_edge,
    input wire rts_pkg::rts_cfg_t cfg,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Chip reset and interrupt
    output logic chip_reset,
    output logic watchdog_reset,
    output logic irq
);
    rts_pkg::rts_state_t state;
    rts_pkg::rts_state_t next_state;
    rts_pkg::rts_bus_req_t req;
    logic brownout_flag;
    logic poweron_flag;
    logic [7:0] events;
    logic [7:0] mask;
    logic [7:0] ctrl;
    logic powerup_timer_running;
    logic powerup_timer_done;
    logic ost_running;
    logic ost_done;
    logic wdt_running;
    logic wdt_done;
    logic powerup_timer_load;
    logic ost_load;
    logic pending_ost;
    logic next_pending_ost;

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // Decode
    wire wr_status = req.wr && (req.addr == rts_pkg::ADDR_STATUS);
    wire wr_mask = req.wr && (req.addr == rts_pkg::ADDR_MASK);
    wire wr_ctrl = req.wr && (req.addr == rts_pkg::ADDR_CTRL);
    wire rd_events = req.rd && (req.addr == rts_pkg::ADDR_EVENTS);
    wire crystal = (cfg.osc_mode != rts_pkg::OSC_RESISTOR_CAPACITOR);
    wire bor_event = brownout_event && cfg.brownout_reset_enable;
    wire wdt_enable = ctrl[rts_pkg::CTL_WDT_EN];
    wire wdt_kick = wr_ctrl && wdata[rts_pkg::CTL_WDT_CLR];

    // Hold-time selection per event
    wire por_powerup_timer = poweron_event && !cfg.powerup_timer_disable;
    wire use_powerup_timer = por_powerup_timer || bor_event;
    wire use_ost = crystal && (poweron_event || bor_event || wakeup_event);
    wire any_event = poweron_event || bor_event || wakeup_event || wdt_done;
    wire released = (state != rts_pkg::ST_RUN) && (next_state == rts_pkg::ST_RUN);
    // Parked at a full count while disabled, so enabling never inherits a stale count
    wire wdt_load = released ||
        ((state == rts_pkg::ST_RUN) && (!wdt_enable || wdt_kick || !wdt_running));
    wire wdt_tick = (state == rts_pkg::ST_RUN) && wdt_enable;

    // Sequencing: events restart the sequence from the top
    always_comb
    begin
        next_state = state;
        next_pending_ost = pending_ost;
        powerup_timer_load = 1'b0;
        ost_load = 1'b0;
        if (any_event)
        begin
            next_pending_ost = use_ost;
            if (use_powerup_timer)
            begin
                powerup_timer_load = 1'b1;
                next_state = rts_pkg::ST_POWERUP_TIMER;
            end
            else if (use_ost)
            begin
                ost_load = 1'b1;
                next_pending_ost = 1'b0;
                next_state = rts_pkg::ST_OST;
            end
            else
            begin
                next_state = rts_pkg::ST_RUN;
            end
        end
        else
        begin
            case (state)
                rts_pkg::ST_IDLE:
                begin
                    next_state = rts_pkg::ST_IDLE;
                end
                rts_pkg::ST_POWERUP_TIMER:
                begin
                    if (powerup_timer_done)
                    begin
                        if (pending_ost)
                        begin
                            ost_load = 1'b1;
                            next_pending_ost = 1'b0;
                            next_state = rts_pkg::ST_OST;
                        end
                        else
                        begin
                            next_state = rts_pkg::ST_RUN;
                        end
                    end
                end
                rts_pkg::ST_OST:
                begin
                    if (ost_done)
                    begin
                        next_state = rts_pkg::ST_RUN;
                    end
                end
                rts_pkg::ST_RUN:
                begin
                    next_state = rts_pkg::ST_RUN;
                end
                default:
                begin
                    next_state = rts_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Power-up timer ticks on the system clock, standing in for the RC timebase
    rts_counter #(.WIDTH(32)) u_powerup_timer (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .load(powerup_timer_load),
        .load_value(32'(POWERUP_TIMER_COUNT)),
        .tick(1'b1),
        .running(powerup_timer_running),
        .done(powerup_timer_done)
    );

    // Start-up count ticks on the oscillator period strobe
    rts_counter #(.WIDTH(11)) u_osc_startup_timer (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .load(ost_load),
        .load_value(11'(rts_pkg::OST_TOSC)),
        .tick(osc_edge),
        .running(ost_running),
        .done(ost_done)
    );

    // Watchdog reloads on kick; a time-out pulses watchdog_reset and leaves chip_reset low
    rts_counter #(.WIDTH(32)) u_watchdog_timer (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .load(wdt_load),
        .load_value(32'(WDT_COUNT)),
        .tick(wdt_tick),
        .running(wdt_running),
        .done(wdt_done)
    );

    // Flags have no reset value: they persist across all but their own events.
    // The brown-out flag after power-on keeps whatever it held.
    always_ff @(posedge clock)
    begin
        if (ce)
        begin
            if (bor_event)
                brownout_flag <= 1'b0;
            else if (wr_status)
                brownout_flag <= wdata[rts_pkg::BIT_BROWNOUT];
            if (poweron_event)
                poweron_flag <= rts_pkg::RST_POWERON_ON_POR[rts_pkg::BIT_POWERON];
            else if (wr_status)
                poweron_flag <= wdata[rts_pkg::BIT_POWERON];
        end
    end

    wire [7:0] ev_set = {5'h0, bor_event, wdt_done, released};
    wire [7:0] status_word = {(state != rts_pkg::ST_RUN), 5'h0, poweron_flag, brownout_flag};
    wire [7:0] read_mux =
        (req.addr == rts_pkg::ADDR_STATUS) ? status_word :
        (req.addr == rts_pkg::ADDR_EVENTS) ? events :
        (req.addr == rts_pkg::ADDR_MASK) ? mask :
        (req.addr == rts_pkg::ADDR_CTRL) ? ctrl : 8'h00;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state <= rts_pkg::ST_IDLE;
            pending_ost <= 1'b0;
            events <= rts_pkg::RST_EVENTS;
            mask <= rts_pkg::RST_MASK;
            ctrl <= rts_pkg::RST_CTRL;
            rdata <= 8'h00;
            chip_reset <= 1'b1;
            watchdog_reset <= 1'b0;
            irq <= 1'b0;
        end
        else if (ce)
        begin
            state <= next_state;
            pending_ost <= next_pending_ost;
            // Set wins over the read that clears
            events <= (rd_events ? 8'h00 : events) | ev_set;
            if (wr_mask)
                mask <= wdata;
            if (wr_ctrl)
                ctrl <= {wdata[7:2], 1'b0, wdata[rts_pkg::CTL_WDT_EN]};
            rdata <= req.rd ? read_mux : 8'h00;
            chip_reset <= (next_state != rts_pkg::ST_RUN);
            watchdog_reset <= wdt_done;
            irq <= |(((rd_events ? 8'h00 : events) | ev_set) & mask);
        end
    end
endmodule // rts_reset_timeout

// *** test/rts_reset_timeout_assertions.sv ***
/*
 Port checker for the reset time-out sequencer.
 Assumes ce held high and cfg held steady while a sequence runs.
*/
module rts_reset_timeout_assertions #(
    parameter int unsigned POWERUP_TIMER_COUNT = 50,
    parameter int unsigned WDT_COUNT = 80
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // Events and configuration
    input wire logic poweron_event,
    input wire logic brownout_event,
    input wire logic wakeup_event,
    input wire logic osc_edge,
    input wire rts_pkg::rts_cfg_t cfg,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // Outputs
    input wire logic chip_reset,
    input wire logic watchdog_reset,
    input wire logic irq
);
    int unsigned cnt;
    int unsigned osc_cnt;
    int unsigned run_cnt;
    logic need_powerup_timer;
    wire logic bo_ev = brownout_event && cfg.brownout_reset_enable;
    wire logic any_ev = poweron_event || bo_ev || wakeup_event || watchdog_reset;
    wire logic is_rc = cfg.osc_mode == rts_pkg::OSC_RESISTOR_CAPACITOR;
    wire logic rd_st = rd && addr == rts_pkg::ADDR_STATUS;
    // Resistor mode holds only for the power-up timer; wake-up there is immediate
    wire logic holds_ev = bo_ev || (wakeup_event && !is_rc)
        || (poweron_event && !(is_rc && cfg.powerup_timer_disable));

    // Counts from the last reset event, so hold times are judged at release
    always_ff @(posedge clock)
    begin
        cnt <= (rst || any_ev) ? 0 : cnt + 1;
        osc_cnt <= (rst || any_ev) ? 0 : osc_cnt + osc_edge;
        if (rst || any_ev)
            need_powerup_timer <= !rst && ((poweron_event && !cfg.powerup_timer_disable) || bo_ev);
        run_cnt <= (rst || chip_reset || watchdog_reset || (wr && addr == rts_pkg::ADDR_CTRL))
            ? 0 : run_cnt + 1;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    chk_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data not zero outside read answer");
    chk_event_holds: assert property (holds_ev |=> chip_reset)
        else $error("reset event did not hold chip in reset");
    chk_powerup_timer_min: assert property ($fell(chip_reset) && need_powerup_timer |-> cnt >= POWERUP_TIMER_COUNT)
        else $error("released before power-up timer ended");
    chk_rc_powerup_timer_max: assert property ($fell(chip_reset) && need_powerup_timer && is_rc |-> cnt <= POWERUP_TIMER_COUNT + 6)
        else $error("resistor mode hold too long");
    chk_osc_count: assert property ($fell(chip_reset) && !is_rc |-> osc_cnt >= 1024)
        else $error("released before start-up count ended");
    chk_rc_wake_free: assert property (wakeup_event && is_rc |-> ##[1:4] !chip_reset)
        else $error("resistor mode wake-up held in reset");
    chk_por_flag_clear: assert property (poweron_event ##[1:3] rd_st |=> !rdata[1])
        else $error("power-on flag not cleared");
    chk_bo_flag_clear: assert property (bo_ev ##[1:3] rd_st |=> !rdata[0])
        else $error("brown-out flag not cleared");
    chk_wdt_period: assert property (watchdog_reset |-> run_cnt inside {[WDT_COUNT - 4:WDT_COUNT + 4]})
        else $error("watchdog period off");
    chk_irq_masked: assert property (wr && addr == rts_pkg::ADDR_MASK && wdata == 8'h00 |=> ##1 !irq)
        else $error("interrupt high with mask cleared");

    cover property ($fell(chip_reset) && need_powerup_timer);
    cover property (watchdog_reset);
    cover property (irq);
    cover property (wakeup_event && is_rc);
endmodule // rts_reset_timeout_assertions

// *** test/rts_reset_timeout_tb_top.sv ***
/*
 Directed bench for the reset time-out sequencer over its register port.
 Assumes shortened timer counts; the oscillator pulses every fourth clock.
*/
module rts_reset_timeout_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PW = 50;
    localparam int WD = 80;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic ce = 1'h1;
    logic poweron_event = 1'h0;
    logic brownout_event = 1'h0;
    logic wakeup_event = 1'h0;
    logic osc_edge = 1'h0;
    logic [1:0] osc_div = 2'h0;
    rts_pkg::rts_cfg_t cfg = '{rts_pkg::OSC_RESISTOR_CAPACITOR, 1'h0, 1'h1};
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'h0;
    logic rd = 1'h0;
    logic [7:0] rdata;
    logic chip_reset;
    logic watchdog_reset;
    logic irq;
    logic [7:0] v;
    int n;
    int err_total = 0;
    int checked = 0;

    rts_reset_timeout #(.POWERUP_TIMER_COUNT(PW), .WDT_COUNT(WD)) dut (.clock(clock), .rst(rst), .ce(ce),
        .poweron_event(poweron_event), .brownout_event(brownout_event),
        .wakeup_event(wakeup_event), .osc_edge(osc_edge), .cfg(cfg), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .chip_reset(chip_reset),
        .watchdog_reset(watchdog_reset), .irq(irq));

    initial
    begin
        forever #12.5 clock = ~clock;
    end

    always @(posedge clock)
    begin
        osc_div <= osc_div + 2'h1;
        osc_edge <= osc_div == 2'h3;
    end

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        wr <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'h0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        rd <= 1'h1;
        addr <= a;
        @(posedge clock);
        rd <= 1'h0;
        #1 d = rdata;
    endtask

    task automatic pulse(input logic [2:0] k);
        @(posedge clock);
        {wakeup_event, brownout_event, poweron_event} <= k;
        @(posedge clock);
        {wakeup_event, brownout_event, poweron_event} <= 3'h0;
    endtask

    // Bounded wait: sel 0 for release, sel 1 for the watchdog pulse
    task automatic wait_for(input bit sel, output int c);
        c = 0;
        #1;
        while ((sel ? !watchdog_reset : chip_reset) !== 1'h0 && c < 6000)
        begin
            @(posedge clock);
            #1;
            c++;
        end
        if (c >= 6000)
            err_total++;
    endtask

    task automatic tally_and_finish();
        if (err_total == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        #(25ns * 20000);
        err_total++;
        tally_and_finish();
    end

    initial
    begin
        repeat (16) @(posedge clock);
        rst <= 1'h0;
        pulse(3'h1);
        rd_reg(rts_pkg::ADDR_STATUS, v);
        chk("status_por", v & 8'h82, 8'h80);
        wait_for(0, n);
        rd_reg(rts_pkg::ADDR_EVENTS, v);
        chk("events_release", v, 8'h01);
        rd_reg(rts_pkg::ADDR_EVENTS, v);
        chk("events_cleared", v, 8'h00);
        wr_reg(rts_pkg::ADDR_EVENTS, 8'hff);
        rd_reg(4'h9, v);
        chk("unmapped", v, 8'h00);
        rd_reg(rts_pkg::ADDR_EVENTS, v);
        chk("events_ro", v, 8'h00);
        wr_reg(rts_pkg::ADDR_STATUS, 8'h03);
        rd_reg(rts_pkg::ADDR_STATUS, v);
        chk("flags_set", v, 8'h03);
        @(posedge clock);
        cfg.osc_mode <= rts_pkg::OSC_CRYSTAL_STANDARD;
        pulse(3'h4);
        wait_for(0, n);
        chk("ost_hold", n >= 4086 && n <= 4110, 8'h01);
        rd_reg(rts_pkg::ADDR_STATUS, v);
        chk("flags_kept", v, 8'h03);
        @(posedge clock);
        cfg <= '{rts_pkg::OSC_RESISTOR_CAPACITOR, 1'h1, 1'h1};
        wr_reg(rts_pkg::ADDR_MASK, 8'h04);
        rd_reg(rts_pkg::ADDR_EVENTS, v);
        pulse(3'h2);
        rd_reg(rts_pkg::ADDR_STATUS, v);
        chk("status_bo", v, 8'h82);
        wait_for(0, n);
        chk("bo_powerup_timer", n >= PW - 4 && n <= PW + 6, 8'h01);
        chk("irq_set", irq, 1'h1);
        rd_reg(rts_pkg::ADDR_EVENTS, v);
        chk("events_bo", v, 8'h05);
        repeat (2) @(posedge clock);
        chk("irq_cleared", irq, 1'h0);
        wr_reg(rts_pkg::ADDR_MASK, 8'h00);
        pulse(3'h4);
        repeat (3) @(posedge clock);
        chk("rc_wake_free", chip_reset, 1'h0);
        cfg.brownout_reset_enable <= 1'h0;
        pulse(3'h2);
        repeat (3) @(posedge clock);
        chk("bo_ignored", chip_reset, 1'h0);
        wr_reg(rts_pkg::ADDR_CTRL, 8'h01);
        wait_for(1, n);
        chk("wdt_period", n >= WD - 8 && n <= WD + 4, 8'h01);
        // Kick halfway through the next period: without it the time-out comes early
        repeat (40) @(posedge clock);
        wr_reg(rts_pkg::ADDR_CTRL, 8'h03);
        wait_for(1, n);
        chk("wdt_kick", n >= WD - 8 && n <= WD + 4, 8'h01);
        wr_reg(rts_pkg::ADDR_CTRL, 8'h00);
        wait_for(0, n);
        rd_reg(rts_pkg::ADDR_EVENTS, v);
        chk("events_wdt", v, 8'h02);
        @(posedge clock);
        ce <= 1'h0;
        wr_reg(rts_pkg::ADDR_MASK, 8'hff);
        ce <= 1'h1;
        rd_reg(rts_pkg::ADDR_MASK, v);
        chk("ce_freeze", v, 8'h00);
        tally_and_finish();
    end
endmodule // rts_reset_timeout_tb_top

bind rts_reset_timeout rts_reset_timeout_assertions #(.POWERUP_TIMER_COUNT(POWERUP_TIMER_COUNT),
    .WDT_COUNT(WDT_COUNT)) u_chk (.clock(clock), .rst(rst), .ce(ce),
    .poweron_event(poweron_event), .brownout_event(brownout_event),
    .wakeup_event(wakeup_event), .osc_edge(osc_edge), .cfg(cfg), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .chip_reset(chip_reset),
    .watchdog_reset(watchdog_reset), .irq(irq));
